// ===== inc/spm_map.svh
`ifndef SPM_MAP_SVH
`define SPM_MAP_SVH

// Register byte offsets
`define SPM_OFS_CTRL   8'h00
`define SPM_OFS_DIV    8'h04
`define SPM_OFS_SEL    8'h08
`define SPM_OFS_TX     8'h0C
`define SPM_OFS_START  8'h10
`define SPM_OFS_RX     8'h14
`define SPM_OFS_STATUS 8'h18

// Control register fields
`define SPM_CTRL_EN    0
`define SPM_CTRL_LSB   1
`define SPM_CTRL_CPOL  2
`define SPM_CTRL_CPHA  3
`define SPM_CTRL_AUTO  4
`define SPM_CTRL_IRQEN 5
`define SPM_CTRL_W     6

// Start register fields
`define SPM_START_LEN_LSB 0
`define SPM_START_LEN_MSB 4
`define SPM_START_CONT    8

// Status register fields
`define SPM_STAT_BUSY 0
`define SPM_STAT_DONE 1
`define SPM_STAT_CONT 2

// Reset values
`define SPM_RST_CTRL 6'h00
`define SPM_RST_DIV  8'h00
`define SPM_RST_SEL  3'h0

// Timing
`define SPM_CLK_MHZ       25
`define SPM_MAX_RATE_MBPS 16
`define SPM_RATE_HALF_CYC ((`SPM_CLK_MHZ + 2 * `SPM_MAX_RATE_MBPS - 1) / (2 * `SPM_MAX_RATE_MBPS))
`define SPM_SYNC_HALF_CYC 3

`endif

// ===== inc/spm_pkg.sv
package spm_pkg;

  typedef enum logic [3:0] {
    SPM_IDLE  = 4'b0001,
    SPM_LEAD  = 4'b0010,
    SPM_SHIFT = 4'b0100,
    SPM_TRAIL = 4'b1000
  } spm_state_t;

  typedef struct packed {
    logic irq_en;
    logic auto_sel;
    logic cpha;
    logic cpol;
    logic lsb_first;
    logic enable;
  } spm_ctrl_t;

  typedef struct packed {
    logic [4:0] len_m1;
    logic       cont;
  } spm_start_t;

endpackage

// ===== core/spm_master.sv
`timescale 1ns/10ps
`default_nettype none
`include "spm_map.svh"

module spm_master #(
  parameter int HALF_MIN = (`SPM_RATE_HALF_CYC > `SPM_SYNC_HALF_CYC) ?
                           `SPM_RATE_HALF_CYC : `SPM_SYNC_HALF_CYC
) (
  input  wire logic        clock,               // Peripheral clock, 25 MHz
  input  wire logic        reset,               // Synchronous, active high
  input  wire logic [7:0]  reg_addr,            // Register byte address
  input  wire logic [31:0] reg_wdata,           // Write data
  input  wire logic        reg_wr,              // Write strobe
  input  wire logic        reg_rd,              // Read strobe
  output logic      [31:0] reg_rdata,           // Read data, cycle after strobe
  output logic             irq,                 // Transfer complete request
  output logic             spi_sclk,            // Serial bit clock
  output logic             spi_mosi,            // Serial data out
  input  wire logic        spi_miso,            // Serial data in
  output logic             slave_select_line_a_n, // Select a, active low
  output logic             slave_select_line_b_n, // Select b, active low
  output logic             slave_select_line_c_n  // Select c, active low
);

  // Below the floor the two-flop data-in path cannot settle before sampling
  if (HALF_MIN < `SPM_SYNC_HALF_CYC || HALF_MIN > 255) begin : g_half_check
    $error("spm_master: HALF_MIN out of range");
  end

  // MSB-first words are moved up so bit len-1 sits at the top
  function automatic logic [31:0] tx_align(input logic [31:0] d, input logic [4:0] lm1,
                                           input logic lsb);
    tx_align = lsb ? d : (d << (5'd31 - lm1));
  endfunction

  // One-bit advance in the chosen direction
  function automatic logic [31:0] tx_step(input logic [31:0] t, input logic lsb);
    tx_step = lsb ? (t >> 1) : (t << 1);
  endfunction

  // Bit that goes on the wire next
  function automatic logic tx_head(input logic [31:0] t, input logic lsb);
    tx_head = lsb ? t[0] : t[31];
  endfunction

  // Sequencer and configuration
  spm_pkg::spm_state_t state_r;
  spm_pkg::spm_state_t state_nxt;
  spm_pkg::spm_ctrl_t  ctrl_r;
  spm_pkg::spm_start_t start_r;
  logic [7:0]  div_r;
  logic [2:0]  sel_pat_r;

  // Staging word, shift registers and received word
  logic [31:0] tx_word_r;
  logic [31:0] tx_sh_r;
  logic [31:0] rx_sh_r;
  logic [31:0] rx_data_r;

  // Bit timing
  logic [7:0]  cnt_r;
  logic [5:0]  edge_r;

  // Registered pin drivers
  logic        sclk_r;
  logic        mosi_r;
  logic [2:0]  sel_n_r;

  // Completion and continuous-mode flags
  logic        done_r;
  logic        cont_r;
  logic        last_r;
  logic        go_r;

  // Data-in synchroniser and read data
  logic        miso_s1_r;
  logic        miso_s2_r;
  logic [31:0] rdata_r;

  // Register decode
  wire wr_ctrl  = reg_wr && (reg_addr == `SPM_OFS_CTRL);
  wire wr_div   = reg_wr && (reg_addr == `SPM_OFS_DIV);
  wire wr_sel   = reg_wr && (reg_addr == `SPM_OFS_SEL);
  wire wr_tx    = reg_wr && (reg_addr == `SPM_OFS_TX);
  wire wr_start = reg_wr && (reg_addr == `SPM_OFS_START);
  wire rd_rx    = reg_rd && (reg_addr == `SPM_OFS_RX);

  // Half period never drops below the synchroniser floor
  wire       en      = ctrl_r.enable;
  wire       lsb     = ctrl_r.lsb_first;
  wire       idle    = (state_r == spm_pkg::SPM_IDLE);
  wire       busy    = !idle;
  wire [7:0] half    = (div_r < 8'(HALF_MIN)) ? 8'(HALF_MIN) : div_r;
  wire       tick    = (cnt_r == half - 8'h01);
  // Edge parity picks sample or drive; phase 1 keeps the preloaded bit on its first edge
  wire [5:0] last_ed = {start_r.len_m1, 1'b1};
  wire       smp_ed  = (edge_r[0] == ctrl_r.cpha);
  wire       drv_ed  = !smp_ed && !(ctrl_r.cpha && (edge_r == 6'h00));

  // Strobes for the shift and trailing phases
  wire       shift_t = (state_r == spm_pkg::SPM_SHIFT) && tick;
  wire       fin     = (state_r == spm_pkg::SPM_TRAIL) && tick;

  // A start write while busy or disabled is dropped; continuous restarts wait for the read
  wire start_ok = wr_start && en && idle;
  wire auto_go  = en && idle && !go_r && (cont_r || last_r) && !done_r;
  wire launch   = en && idle && (go_r || auto_go);

  // Line c is dropped when b is also asked for
  wire [2:0] sel_eff = {sel_pat_r[2] && !sel_pat_r[1], sel_pat_r[1], sel_pat_r[0]};
  wire       sel_on  = en && (!ctrl_r.auto_sel || busy);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      spm_pkg::SPM_IDLE:  if (launch) state_nxt = spm_pkg::SPM_LEAD;
      spm_pkg::SPM_LEAD:  if (tick) state_nxt = spm_pkg::SPM_SHIFT;
      spm_pkg::SPM_SHIFT: if (tick && edge_r == last_ed) state_nxt = spm_pkg::SPM_TRAIL;
      spm_pkg::SPM_TRAIL: if (tick) state_nxt = spm_pkg::SPM_IDLE;
      default:            state_nxt = spm_pkg::SPM_IDLE;
    endcase
    // Disable overrides everything and drops any transfer in flight
    if (!en) begin
      state_nxt = spm_pkg::SPM_IDLE;
    end
  end

  // Data in comes from another domain, so it is synchronised first
  always_ff @(posedge clock) begin
    miso_s1_r <= spi_miso;
    miso_s2_r <= miso_s1_r;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl_r    <= `SPM_RST_CTRL;
      div_r     <= `SPM_RST_DIV;
      sel_pat_r <= `SPM_RST_SEL;
      tx_word_r <= 32'h0000_0000;
      start_r   <= '0;
    end else begin
      // Configuration writes land at the strobe edge
      if (wr_ctrl) ctrl_r <= reg_wdata[`SPM_CTRL_W-1:0];
      if (wr_div) div_r <= reg_wdata[7:0];
      if (wr_sel) sel_pat_r <= reg_wdata[2:0];
      if (wr_tx) tx_word_r <= reg_wdata;
      // Start fields are latched only when the start is accepted
      if (start_ok) begin
        start_r.len_m1 <= reg_wdata[`SPM_START_LEN_MSB:`SPM_START_LEN_LSB];
        start_r.cont   <= reg_wdata[`SPM_START_CONT];
      end
    end
  end

  // Continuous-mode bookkeeping
  // go_r holds an accepted start until the sequencer takes it
  always_ff @(posedge clock) begin
    if (reset || !en) begin
      go_r   <= 1'b0;
      cont_r <= 1'b0;
      last_r <= 1'b0;
    end else begin
      if (start_ok) begin
        go_r   <= 1'b1;
        cont_r <= reg_wdata[`SPM_START_CONT];
      end else if (launch) begin
        go_r <= 1'b0;
      end
      // A stop request is honoured even while busy; last_r arms
      // the single transfer that still follows it
      if (wr_start && cont_r && !reg_wdata[`SPM_START_CONT]) begin
        cont_r <= 1'b0;
        last_r <= 1'b1;
      end else if (launch && !go_r && last_r) begin
        last_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_r <= spm_pkg::SPM_IDLE;
      cnt_r   <= 8'h00;
      edge_r  <= 6'h00;
    end else begin
      // Half-period counter runs only outside idle
      state_r <= state_nxt;
      cnt_r   <= (idle || tick) ? 8'h00 : cnt_r + 8'h01;
      // Edge counter restarts in the lead phase so each transfer counts from zero
      if (state_r == spm_pkg::SPM_LEAD) edge_r <= 6'h00;
      else if (shift_t) edge_r <= edge_r + 6'h01;
    end
  end

  // Shift engine
  always_ff @(posedge clock) begin
    if (reset) begin
      tx_sh_r <= 32'h0000_0000;
      rx_sh_r <= 32'h0000_0000;
      mosi_r  <= 1'b0;
    end else if (launch) begin
      tx_sh_r <= tx_step(tx_align(tx_word_r, start_r.len_m1, lsb), lsb);
      mosi_r  <= tx_head(tx_align(tx_word_r, start_r.len_m1, lsb), lsb);
      // Cleared so short words read back zero-extended
      rx_sh_r <= 32'h0000_0000;
    end else if (shift_t) begin
      if (smp_ed) begin
        rx_sh_r <= lsb ? {miso_s2_r, rx_sh_r[31:1]} : {rx_sh_r[30:0], miso_s2_r};
      end
      // Drive happens on the edge opposite to sampling
      if (drv_ed) begin
        mosi_r  <= tx_head(tx_sh_r, lsb);
        tx_sh_r <= tx_step(tx_sh_r, lsb);
      end
    end
  end

  // Bit clock rests at the polarity level outside the shift phase
  always_ff @(posedge clock) begin
    if (reset) begin
      sclk_r <= 1'b0;
    end else if (state_r != spm_pkg::SPM_SHIFT) begin
      sclk_r <= ctrl_r.cpol;
    end else if (tick) begin
      sclk_r <= !sclk_r;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      rx_data_r <= 32'h0000_0000;
      done_r    <= 1'b0;
      sel_n_r   <= 3'h7;
    end else begin
      // LSB-first words arrive at the top and are shifted down
      if (fin) begin
        rx_data_r <= lsb ? (rx_sh_r >> (5'd31 - start_r.len_m1)) : rx_sh_r;
      end
      // Set wins over the read clear, so a finishing transfer is never lost
      if (fin) done_r <= 1'b1;
      else if (rd_rx) done_r <= 1'b0;
      // Registered so the selects never glitch between patterns
      sel_n_r <= ~(sel_eff & {3{sel_on}});
    end
  end

  // Unmapped offsets read zero
  wire [31:0] rd_mux =
    (reg_addr == `SPM_OFS_CTRL)   ? {26'h0, ctrl_r} :
    (reg_addr == `SPM_OFS_DIV)    ? {24'h0, div_r} :
    (reg_addr == `SPM_OFS_SEL)    ? {29'h0, sel_pat_r} :
    (reg_addr == `SPM_OFS_TX)     ? tx_word_r :
    (reg_addr == `SPM_OFS_START)  ? {23'h0, start_r.cont, 3'h0, start_r.len_m1} :
    (reg_addr == `SPM_OFS_RX)     ? rx_data_r :
    (reg_addr == `SPM_OFS_STATUS) ? {29'h0, cont_r, done_r, busy} :
                                    32'h0000_0000;

  // Read data stands for one cycle only, then returns to zero
  always_ff @(posedge clock) begin
    if (reset) rdata_r <= 32'h0000_0000;
    else if (reg_rd) rdata_r <= rd_mux;
    else rdata_r <= 32'h0000_0000;
  end

  // Data outputs straight from flip-flops
  assign reg_rdata             = rdata_r;
  // Request is a level of enable and done, cleared by reading the received word
  assign irq                   = ctrl_r.irq_en && done_r;
  assign spi_sclk              = sclk_r;
  assign spi_mosi              = mosi_r;
  assign slave_select_line_a_n = sel_n_r[0];
  assign slave_select_line_b_n = sel_n_r[1];
  assign slave_select_line_c_n = sel_n_r[2];

endmodule

`default_nettype wire

// ===== sim/spm_master_asserts.sv
`timescale 1ns/10ps
`default_nettype none
`include "spm_map.svh"
module spm_master_asserts #(
  parameter int HALF_MIN = 3
) (
  input wire logic        clock,                 // Clock
  input wire logic        reset,                 // Reset
  input wire logic [7:0]  reg_addr,              // Address
  input wire logic [31:0] reg_wdata,             // Write data
  input wire logic        reg_wr,                // Write
  input wire logic        reg_rd,                // Read
  input wire logic        irq,                   // Request
  input wire logic        spi_sclk,              // Bit clock
  input wire logic        spi_mosi,              // Data out
  input wire logic        slave_select_line_a_n, // Select a
  input wire logic        slave_select_line_b_n, // Select b
  input wire logic        slave_select_line_c_n  // Select c
);
  spm_pkg::spm_ctrl_t ctrl_r;
  logic [2:0]         sel_exp_r;
  logic [2:0]         auto_r;
  logic               sclk_r;
  logic               off_r;
  logic [7:0]         age_r;
  wire all_off = slave_select_line_a_n & slave_select_line_b_n & slave_select_line_c_n;
  wire chg     = spi_sclk != sclk_r;
  wire lead    = chg && spi_sclk != ctrl_r.cpol;
  wire smp     = chg && ((spi_sclk != ctrl_r.cpol) ^ ctrl_r.cpha);
  wire act     = chg || (off_r && !all_off);
  wire sel_wr  = reg_wr && reg_addr == `SPM_OFS_SEL;
  wire [2:0] pins = {slave_select_line_c_n, slave_select_line_b_n, slave_select_line_a_n};
  // Age since the last bus activity; saturates so idle time stays readable
  always_ff @(posedge clock) begin
    sclk_r <= reset ? 1'b0 : spi_sclk;
    off_r <= all_off;
    auto_r <= {auto_r[1:0], ctrl_r.auto_sel};
    age_r <= (reset || act) ? 8'h01 : age_r + {7'h0, age_r != 8'hFF};
    if (sel_wr) sel_exp_r <= ~{reg_wdata[2] & ~reg_wdata[1], reg_wdata[1:0]};
    if (reset) ctrl_r <= '0;
    else if (reg_wr && reg_addr == `SPM_OFS_CTRL) ctrl_r <= spm_pkg::spm_ctrl_t'(reg_wdata[5:0]);
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  a_sel_pair: assert property (slave_select_line_b_n | slave_select_line_c_n)
    else $error("select b and c active together");
  a_reset_idle: assert property ($past(reset) |-> !spi_sclk && all_off)
    else $error("bus not idle after reset");
  a_half_min: assert property (chg |-> age_r >= HALF_MIN)
    else $error("bit clock half period too short");
  a_sel_lead: assert property (lead |-> !all_off)
    else $error("leading edge without a select");
  a_mosi_hold: assert property (smp |-> $stable(spi_mosi))
    else $error("data out moved at sample edge");
  // Bench keeps the divisor small, so 40 quiet cycles means no transfer
  a_auto_off: assert property (&auto_r && ctrl_r.auto_sel && age_r > 8'd40 |-> all_off)
    else $error("automatic select held while idle");
  a_manual_sel: assert property (sel_wr && ctrl_r.enable && !ctrl_r.auto_sel |-> ##2 pins == sel_exp_r)
    else $error("manual select pattern not applied");
  a_irq_done: assert property ($rose(irq) |-> ctrl_r.irq_en && spi_sclk == ctrl_r.cpol)
    else $error("request raised outside completion");
  a_irq_clear: assert property (reg_rd && reg_addr == `SPM_OFS_RX |=> !irq)
    else $error("request kept after receive read");
  c_mode3: cover property (lead && ctrl_r.cpol && ctrl_r.cpha);
  c_irq: cover property ($rose(irq));
  c_manual: cover property (sel_wr && !ctrl_r.auto_sel);
endmodule
bind spm_master spm_master_asserts #(.HALF_MIN(HALF_MIN)) i_asserts (
  .clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .irq(irq), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi),
  .slave_select_line_a_n(slave_select_line_a_n), .slave_select_line_b_n(slave_select_line_b_n),
  .slave_select_line_c_n(slave_select_line_c_n));
`default_nettype wire

// ===== sim/spm_slave_model.sv
`timescale 1ns/10ps
`default_nettype none
module spm_slave_model (
  input  wire logic clock, // Bench clock
  input  wire logic sclk,  // Bit clock
  input  wire logic mosi,  // Data from master
  input  wire logic sel_n, // Select, active low
  input  wire logic cpol,  // Idle level
  input  wire logic cpha,  // Trailing sample
  output logic      miso   // Data to master
);
  logic [31:0] sh = 32'h0;
  logic [31:0] rx = 32'h0;
  logic        junk = 1'b0;
  int          nsh = 0;
  task load(input logic [31:0] w);
    sh = w;
    rx = 32'h0;
    nsh = 0;
  endtask
  // Released line changes every cycle so a stale bit never reads as data
  always @(posedge clock) junk <= ~junk;
  assign miso = sel_n ? junk : sh[31];
  // Follows the master's clock only and never drives one
  always @(sclk) begin
    if (!sel_n && ((sclk != cpol) ^ cpha)) begin
      rx = {rx[30:0], mosi};
    end else if (!sel_n) begin
      if (nsh > 0 || !cpha) sh = {sh[30:0], 1'b0};
      nsh = nsh + 1;
    end
  end
endmodule
`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "spm_map.svh"
module tb;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        cpol = 1'b0;
  logic        cpha = 1'b0;
  logic [31:0] reg_rdata, got, tx, sw;
  logic        irq, sclk, mosi, miso, sel_a_n, sel_b_n, sel_c_n;
  int          err_count = 0;
  int          n_tests = 0;
  int          seed = 44697;
  always #20 clock = ~clock;
  spm_master #(.HALF_MIN(3)) i_dut (.clock(clock), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .spi_sclk(sclk), .spi_mosi(mosi), .spi_miso(miso), .slave_select_line_a_n(sel_a_n),
    .slave_select_line_b_n(sel_b_n), .slave_select_line_c_n(sel_c_n));
  spm_slave_model i_slave (.clock(clock), .sclk(sclk), .mosi(mosi), .sel_n(sel_a_n),
    .cpol(cpol), .cpha(cpha), .miso(miso));
  task results;
    if (err_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 got = reg_rdata;
  endtask
  // Expected words follow the line order: bit 0 goes first when LSB-first, bit n-1 when MSB-first; the slave sends sw from bit 31
  task finish_xfer(input int n, input bit lsb, input bit ien);
    logic [31:0] e_rx, e_sl;
    int          k;
    e_rx = 32'h0;
    e_sl = 32'h0;
    for (k = 0; k < n; k++) begin
      e_rx[lsb ? k : n - 1 - k] = sw[31 - k];
      e_sl[n - 1 - k] = tx[lsb ? k : n - 1 - k];
    end
    rd(`SPM_OFS_STATUS);
    chk("busy", 32'h1, {31'h0, got[`SPM_STAT_BUSY]});
    for (k = 0; k < 3000; k++) begin
      rd(`SPM_OFS_STATUS);
      if (got[`SPM_STAT_DONE] === 1'b1) break;
    end
    if (k == 3000) begin
      err_count++;
      results();
    end
    chk("busy", 32'h0, {31'h0, got[`SPM_STAT_BUSY]});
    chk("irq", {31'h0, ien}, {31'h0, irq});
    chk("slave", e_sl, i_slave.rx);
    i_slave.load(sw);
    rd(`SPM_OFS_RX);
    chk("rx", e_rx, got);
  endtask
  initial begin
    int i;
    int n;
    bit ien;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    for (i = 0; i < 5; i++) begin
      rd(8'(i < 3 ? i * 4 : i * 4 + 12));
      chk("reset", 32'h0, got);
    end
    for (i = 0; i < 16; i++) begin
      n = (i < 2) ? 1 + 31 * i : 1 + $unsigned($random(seed)) % 32;
      ien = i[0] ^ i[2];
      cpol <= i[1];
      cpha <= i[0];
      wr(`SPM_OFS_CTRL, {26'h0, ien, i[3], i[0], i[1], i[2], 1'b1});
      wr(`SPM_OFS_DIV, 32'd3 + 32'($unsigned($random(seed)) % 4));
      wr(`SPM_OFS_SEL, i[3] ? 32'h1 : (i[0] ? 32'h3 : 32'h5));
      tx = $random(seed);
      sw = $random(seed);
      wr(`SPM_OFS_TX, tx);
      i_slave.load(sw);
      wr(`SPM_OFS_START, 32'(n - 1));
      finish_xfer(n, i[2], ien);
    end
    cpol <= 1'b0;
    cpha <= 1'b0;
    wr(`SPM_OFS_CTRL, 32'h21);
    wr(`SPM_OFS_SEL, 32'h7);
    i_slave.load(sw);
    wr(`SPM_OFS_START, 32'h107);
    finish_xfer(8, 1'b0, 1'b1);
    wr(`SPM_OFS_START, 32'h7);
    finish_xfer(8, 1'b0, 1'b1);
    finish_xfer(8, 1'b0, 1'b1);
    repeat (300) @(posedge clock);
    rd(`SPM_OFS_STATUS);
    chk("status", 32'h0, got);
    wr(`SPM_OFS_SEL, 32'h0);
    repeat (2) @(posedge clock);
    #1 chk("sel", 32'h7, {29'h0, sel_c_n, sel_b_n, sel_a_n});
    wr(`SPM_OFS_CTRL, 32'h4);
    wr(`SPM_OFS_START, 32'h1F);
    repeat (20) @(posedge clock);
    rd(`SPM_OFS_STATUS);
    chk("status", 32'h0, got);
    chk("sclk", 32'h1, {31'h0, sclk});
    results();
  end
endmodule
`default_nettype wire
